// *** hw/trc_top.sv ***
/*
 * transient response control path of the power stage: error word
 * quantiser and overshoot/undershoot pulse generation around a held
 * reference. assumes all inputs are synchronous to clk and the
 * controller takes error words and pulses as they appear.
 */
`timescale 1ns/1ps
module trc_top (
    input wire logic clk,
    input wire logic rst,
    input trc_pkg::trc_sample_s sample,
    input trc_pkg::trc_cfg_s cfg,
    output logic [trc_pkg::ERR_W-1:0] error_word,
    output logic error_valid,
    output logic overshoot_pulse,
    output logic undershoot_pulse,
    output trc_pkg::trc_volt_t transient_reference_level
);
    import trc_pkg::*;

    logic [OFS_W-1:0] over_ofs;
    logic [OFS_W-1:0] under_ofs;
    trc_volt_t next_ref;
    logic [OFS_W-1:0] next_over_ofs;
    logic [OFS_W-1:0] next_under_ofs;
    trc_volt_t over_thr;
    trc_volt_t under_thr;
    logic [ERR_W-1:0] next_error_word;
    logic next_error_valid;
    logic over_flag;
    logic under_flag;
    logic signed [WIDE_W-1:0] diff;
    logic signed [WIDE_W-1:0] scaled;

    // threshold a number of 7.5 mv steps above or below reference
    function automatic trc_volt_t thr_calc(input trc_volt_t ref_in,
                                           input logic [OFS_W-1:0] code,
                                           input logic up);
        logic [WIDE_W-1:0] span;
        logic [WIDE_W-1:0] wide_ref;
        logic [WIDE_W-1:0] sum;
        span = WIDE_W'(code) * WIDE_W'(STEP_LSB);
        wide_ref = WIDE_W'(ref_in);
        if (up) begin
            sum = wide_ref + span;
            thr_calc = (sum > WIDE_W'(VOLT_MAX)) ? VOLT_MAX
                                                 : sum[VOLT_W-1:0];
        end else begin
            thr_calc = (span > wide_ref) ? '0
                                         : VOLT_W'(wide_ref - span);
        end
    endfunction

    // reference and offsets held until reloaded
    always_comb begin
        next_ref = transient_reference_level;
        next_over_ofs = over_ofs;
        next_under_ofs = under_ofs;
        if (cfg.ref_load) begin
            next_ref = cfg.ref_level;
        end
        if (cfg.ofs_load) begin
            next_over_ofs = cfg.over_ofs;
            next_under_ofs = cfg.under_ofs;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transient_reference_level <= REF_RESET;
            over_ofs <= OVER_OFS_RESET;
            under_ofs <= UNDER_OFS_RESET;
        end else begin
            transient_reference_level <= next_ref;
            over_ofs <= next_over_ofs;
            under_ofs <= next_under_ofs;
        end
    end

    // both thresholds measured from the held reference
    assign over_thr = thr_calc(transient_reference_level, over_ofs,
                               1'b1);
    assign under_thr = thr_calc(transient_reference_level, under_ofs,
                                1'b0);

    // error: output minus reference, shifted and saturated to 6 bits
    always_comb begin
        diff = $signed(WIDE_W'(sample.level))
             - $signed(WIDE_W'(transient_reference_level));
        scaled = diff >>> ERR_SHIFT;
        next_error_valid = sample.valid;
        next_error_word = error_word;
        if (sample.valid) begin
            if (scaled > ERR_MAX) begin
                next_error_word = ERR_MAX[ERR_W-1:0];
            end else if (scaled < ERR_MIN) begin
                next_error_word = ERR_MIN[ERR_W-1:0];
            end else begin
                next_error_word = scaled[ERR_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            error_word <= ERR_RESET;
            error_valid <= 1'b0;
            overshoot_pulse <= 1'b0;
            undershoot_pulse <= 1'b0;
        end else begin
            error_word <= next_error_word;
            error_valid <= next_error_valid;
            overshoot_pulse <= over_flag;
            undershoot_pulse <= under_flag;
        end
    end

    trc_window_cmp u_cmp (
        .clk(clk),
        .rst(rst),
        .sample(sample),
        .over_thr(over_thr),
        .under_thr(under_thr),
        .over_flag(over_flag),
        .under_flag(under_flag)
    );

    // helper terms for checking
    logic above;
    logic below;
    assign above = sample.valid && (sample.level > over_thr);
    assign below = sample.valid && (sample.level < under_thr);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_above;
        above;
    endsequence

    sequence s_inside;
        sample.valid && !above && !below;
    endsequence

    a_ref_capture: assert property (cfg.ref_load |=>
        (transient_reference_level == $past(cfg.ref_level)))
        else $error("reference not captured on load");

    a_over_step: assert property (cfg.ofs_load
        && cfg.over_ofs == 5'h02 |=> (over_ofs == 5'h02)
        && (32'(over_thr) == 32'(transient_reference_level) + 6
            || over_thr == VOLT_MAX))
        else $error("overshoot threshold not two 7.5 mv steps up");

    a_under_indep: assert property (cfg.ofs_load
        |=> (under_ofs == $past(cfg.under_ofs))
        && (over_ofs == $past(cfg.over_ofs)))
        else $error("threshold offsets not loaded independently");

    a_over_sets: assert property (s_above |-> ##2 overshoot_pulse
        && !undershoot_pulse)
        else $error("overshoot pulse missing two cycles after sample");

    a_under_sets: assert property (below && !above
        |-> ##2 undershoot_pulse && !overshoot_pulse)
        else $error("undershoot pulse missing two cycles after sample");

    a_pulse_ends: assert property (s_inside
        |-> ##2 !overshoot_pulse && !undershoot_pulse)
        else $error("pulse kept while voltage inside window");

    a_pulse_hold: assert property (!sample.valid |=> ##1
        $stable(overshoot_pulse) && $stable(undershoot_pulse))
        else $error("pulse changed without a new sample");

    a_err_valid: assert property (sample.valid |=> error_valid
        ##1 (error_valid == $past(sample.valid)))
        else $error("error word not sent one cycle after sample");

    a_err_zero: assert property (sample.valid
        && sample.level == transient_reference_level
        |=> error_word == ERR_RESET)
        else $error("zero difference gave nonzero error word");

    a_over_thr_span: assert property (over_thr
        >= transient_reference_level)
        else $error("overshoot threshold below reference");

    a_under_thr_span: assert property (under_thr
        <= transient_reference_level)
        else $error("undershoot threshold above reference");

    a_under_step: assert property (cfg.ofs_load
        && cfg.under_ofs == 5'h02 |=> (under_ofs == 5'h02)
        && (32'(under_thr) + 6 == 32'(transient_reference_level)
            || under_thr == '0))
        else $error("undershoot threshold not two 7.5 mv steps down");

    a_pulse_excl: assert property (!(overshoot_pulse
        && undershoot_pulse))
        else $error("both transient pulses high together");

    a_err_hold: assert property (!sample.valid
        |=> $stable(error_word))
        else $error("error word changed without a sample");

    a_err_quiet: assert property (!sample.valid
        |=> !error_valid)
        else $error("error valid raised without a sample");

    a_err_neg: assert property (sample.valid
        && sample.level < transient_reference_level
        |=> error_word[ERR_W-1])
        else $error("low output gave non-negative error word");

    a_err_pos: assert property (sample.valid
        && sample.level >= transient_reference_level
        |=> !error_word[ERR_W-1])
        else $error("high output gave negative error word");

    a_ref_hold: assert property (!cfg.ref_load
        |=> $stable(transient_reference_level))
        else $error("reference moved without a load");

    a_ofs_hold: assert property (!cfg.ofs_load
        |=> $stable(over_ofs) && $stable(under_ofs))
        else $error("threshold offsets moved without a load");
endmodule

// *** hw/trc_pkg.sv ***
/*
 * constants, types and carriers for the transient response control
 * path of the power stage. assumes a single 20 mhz clock and voltage
 * samples arriving already digitised as unsigned codes.
 */
// Function
// - quantise output minus reference to 6-bit error
// - transient pulses only outside voltage window
// - reference held at load-line midpoint, thresholds relative
// - overshoot and undershoot thresholds set independently
// - overshoot pulse while voltage above overshoot threshold
// - undershoot pulse while voltage below undershoot threshold
// - threshold offsets programmable in 7.5mV steps
package trc_pkg;
    localparam int VOLT_W = 12;
    localparam int ERR_W = 6;
    localparam int OFS_W = 5;
    localparam int WIDE_W = 14;
    // voltage code resolution and threshold step, microvolts
    localparam int LSB_UV = 2500;
    localparam int STEP_UV = 7500;
    localparam int STEP_LSB = STEP_UV / LSB_UV;
    // error word drops this many low bits of the difference
    localparam int ERR_SHIFT = 1;
    localparam logic signed [WIDE_W-1:0] ERR_MAX = 14'sh001f;
    localparam logic signed [WIDE_W-1:0] ERR_MIN = -14'sh0020;
    localparam logic [VOLT_W-1:0] VOLT_MAX = 12'hfff;
    localparam logic [VOLT_W-1:0] REF_RESET = 12'h01e0;
    localparam logic [OFS_W-1:0] OVER_OFS_RESET = 5'h04;
    localparam logic [OFS_W-1:0] UNDER_OFS_RESET = 5'h04;
    localparam logic [ERR_W-1:0] ERR_RESET = 6'h00;

    typedef logic [VOLT_W-1:0] trc_volt_t;

    typedef struct packed {
        logic valid;
        trc_volt_t level;
    } trc_sample_s;

    typedef struct packed {
        logic ref_load;
        trc_volt_t ref_level;
        logic ofs_load;
        logic [OFS_W-1:0] over_ofs;
        logic [OFS_W-1:0] under_ofs;
    } trc_cfg_s;

    typedef enum logic [1:0] {
        TRC_WIN_IN = 2'b00,
        TRC_WIN_OVER = 2'b01,
        TRC_WIN_UNDER = 2'b10
    } trc_win_e;
endpackage

// *** hw/trc_window_cmp.sv ***
/*
 * window comparator: flags samples above the overshoot threshold or
 * below the undershoot threshold. assumes thresholds are stable codes
 * in the same units as the samples.
 */
`timescale 1ns/1ps
module trc_window_cmp (
    input wire logic clk,
    input wire logic rst,
    input trc_pkg::trc_sample_s sample,
    input wire trc_pkg::trc_volt_t over_thr,
    input wire trc_pkg::trc_volt_t under_thr,
    output logic over_flag,
    output logic under_flag
);
    import trc_pkg::*;

    trc_win_e state;
    trc_win_e next_state;

    // state only moves on a fresh sample; overshoot checked first
    always_comb begin
        next_state = state;
        if (sample.valid) begin
            if (sample.level > over_thr) begin
                next_state = TRC_WIN_OVER;
            end else if (sample.level < under_thr) begin
                next_state = TRC_WIN_UNDER;
            end else begin
                next_state = TRC_WIN_IN;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TRC_WIN_IN;
        end else begin
            state <= next_state;
        end
    end

    assign over_flag = (state == TRC_WIN_OVER);
    assign under_flag = (state == TRC_WIN_UNDER);
endmodule

// *** tb/trc_ctrl_model.sv ***
/*
 * controller-side model: picks one transient mode from the two pulses
 * and merges pulses into the drive commands. assumes clk domain only.
 */
`timescale 1ns/1ps
module trc_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic overshoot_pulse,
    input wire logic undershoot_pulse,
    input wire logic sync_low_side_signal,
    input wire logic sync_high_side_signal,
    input wire logic [5:0] error_word,
    input wire logic error_valid,
    output logic low_side_drive_cmd,
    output logic high_side_pwm
);
    logic [1:0] so;
    logic [1:0] su;
    logic [1:0] mode;
    logic signed [15:0] proportional_gain;
    logic signed [15:0] integral_gain;
    logic signed [15:0] derivative_gain;
    logic signed [15:0] integ;
    logic signed [15:0] last_err;
    logic signed [15:0] pid_cmd;
    logic [1:0] phase_sel;
    // gains taken while reset holds, standing in for stored factors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            proportional_gain <= 16'sh0004;
            integral_gain <= 16'sh0001;
            derivative_gain <= 16'sh0002;
            integ <= 16'sh0000;
            last_err <= 16'sh0000;
            pid_cmd <= 16'sh0000;
            phase_sel <= 2'h0;
        end else begin
            phase_sel <= phase_sel + 2'h1; // four phases, tp/n apart
            if (error_valid) begin
                integ <= integ + integral_gain * $signed(error_word);
                pid_cmd <= proportional_gain * $signed(error_word) + integ
                    + derivative_gain * ($signed(error_word) - last_err);
                last_err <= 16'($signed(error_word));
            end
        end
    end
    // two-flop sync, idle mode after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            so <= 2'h0;
            su <= 2'h0;
            mode <= 2'h0;
        end else begin
            so <= {so[0], overshoot_pulse};
            su <= {su[0], undershoot_pulse};
            if (mode == 2'h0) begin
                mode <= so[1] ? 2'h1 : (su[1] ? 2'h2 : 2'h0);
            end else if (!so[1] && !su[1]) begin
                mode <= 2'h0; // one idle cycle, 50 ns
            end
        end
    end
    // merged commands
    assign low_side_drive_cmd = (mode == 2'h2) ? 1'b0 :
        sync_low_side_signal | (mode == 2'h1 && so[1]);
    assign high_side_pwm = (mode == 2'h1) ? 1'b0 :
        sync_high_side_signal | (mode == 2'h2 && su[1]);
endmodule

// *** tb/transient_response_control_tb.sv ***
/*
 * self-checking bench for trc_top with a controller model.
 * assumes one-cycle error latency and two-cycle pulse latency.
 */
`timescale 1ns/1ps
module transient_response_control_tb;
    import trc_pkg::*;
    logic clk, rst, sls, shs, lsd, hsp;
    trc_sample_s sample;
    trc_cfg_s cfg;
    logic [ERR_W-1:0] error_word, ew;
    logic error_valid, overshoot_pulse, undershoot_pulse;
    logic ev, co, cu, po, pu;
    trc_volt_t transient_reference_level, rf;
    logic [OFS_W-1:0] oo, uo;
    int err_count, cmp_count, cyc, seed, lv;
    trc_volt_t cref[4] = '{12'hff0, 12'h000, 12'h800, 12'h123};
    logic [OFS_W-1:0] cofs[4] = '{5'h1f, 5'h02, 5'h1f, 5'h00};
    trc_top trc_top_i (.clk(clk), .rst(rst), .sample(sample), .cfg(cfg),
        .error_word(error_word), .error_valid(error_valid),
        .overshoot_pulse(overshoot_pulse),
        .undershoot_pulse(undershoot_pulse),
        .transient_reference_level(transient_reference_level));
    trc_ctrl_model trc_ctrl_model_i (.clk(clk), .rst(rst),
        .overshoot_pulse(overshoot_pulse),
        .undershoot_pulse(undershoot_pulse), .sync_low_side_signal(sls),
        .sync_high_side_signal(shs), .error_word(error_word),
        .error_valid(error_valid), .low_side_drive_cmd(lsd),
        .high_side_pwm(hsp));
    function automatic int othr(); // 3 lsb per step
        int s;
        s = int'(rf) + 3 * int'(oo);
        return (s > 4095) ? 4095 : s;
    endfunction
    function automatic int uthr();
        return (int'(rf) - 3 * int'(uo) < 0) ? 0 : int'(rf) - 3 * int'(uo);
    endfunction
    function automatic logic [ERR_W-1:0] err_of(int v);
        int d;
        d = (v - int'(rf)) >>> 1;
        d = (d > 31) ? 31 : ((d < -32) ? -32 : d);
        return d[ERR_W-1:0];
    endfunction
    task automatic check(input logic [11:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m,
                got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rf <= REF_RESET;
            oo <= OVER_OFS_RESET;
            uo <= UNDER_OFS_RESET;
            ew <= ERR_RESET;
            {ev, co, cu, po, pu} <= 5'h00;
        end else begin
            ev <= sample.valid;
            po <= co;
            pu <= cu;
            if (sample.valid) begin
                ew <= err_of(int'(sample.level));
                co <= int'(sample.level) > othr();
                cu <= int'(sample.level) < uthr()
                    && int'(sample.level) <= othr();
            end
            if (cfg.ref_load) rf <= cfg.ref_level;
            if (cfg.ofs_load) begin
                oo <= cfg.over_ofs;
                uo <= cfg.under_ofs;
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            results();
        end
    end
    always @(negedge clk) begin
        if (!rst) begin
            check({11'h000, error_valid}, {11'h000, ev}, "valid");
            check({6'h00, error_word}, {6'h00, ew}, "error");
            check({11'h000, overshoot_pulse}, {11'h000, po}, "over");
            check({11'h000, undershoot_pulse}, {11'h000, pu}, "under");
            check(transient_reference_level, rf, "ref");
        end
    end
    initial begin
        seed = 32'h0000_237c;
        {rst, sls, shs} = 3'h4;
        sample = '0;
        cfg = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int t = 0; t < 12; t++) begin
            cfg.ref_load <= 1'b1;
            cfg.ofs_load <= 1'b1;
            cfg.ref_level <= (t < 4) ? cref[t] : 12'($random(seed));
            cfg.over_ofs <= (t < 4) ? cofs[t] : 5'($random(seed));
            cfg.under_ofs <= (t < 4) ? cofs[3 - t] : 5'($random(seed));
            @(posedge clk);
            cfg <= '0;
            repeat (2) @(posedge clk);
            for (int k = 0; k < 60; k++) begin
                lv = int'(rf) + $random(seed) % 101;
                lv = (k % 8 == 0) ? othr() : ((k % 8 == 4) ? uthr() : lv);
                lv = (k % 8 == 2) ? int'(rf) : lv;
                sample.level <= 12'((lv < 0) ? 0 : ((lv > 4095) ? 4095 : lv));
                sample.valid <= ($random(seed) % 4) != 0;
                sls <= 1'($random(seed));
                shs <= 1'($random(seed));
                @(posedge clk);
            end
            sample.valid <= 1'b0;
            repeat (3) @(posedge clk);
            $display("test %0d done", t);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test reset done");
        results();
    end
endmodule
